// ==== bench/ctp_load_model.sv ====
// external load on the timer pin: counts cycles at high level
`timescale 1ns/10ps
`default_nettype none
module ctp_load_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic pinOut,
	input wire logic pinOe,
	input wire logic clr,
	output var int highCnt
);
	wire logic lineLvl;
	// pull-up on the load line, so a released pin reads high
	assign lineLvl = pinOe ? pinOut : 1'b1;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			highCnt <= 0;
		else if (clr)
			highCnt <= 0;
		else if (lineLvl === 1'b1)
			highCnt <= highCnt + 1;
	end
endmodule : ctp_load_model
`default_nettype wire

// ==== bench/ctp_timer_tb.sv ====
// self-checking bench for the compact timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin numErrors++; $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module ctp_timer_tb;
	import ctp_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wrData = '0;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic clr = 1'b0;
	logic [DATA_W-1:0] rdData;
	logic pinOut;
	logic pinOe;
	logic matchAEvt;
	logic matchPEvt;
	logic [DATA_W-1:0] d;
	int highCnt;
	int aCnt = 0;
	int pCnt = 0;
	int cyc = 0;
	int numErrors = 0;
	int samplesChecked = 0;
	logic [7:0] c1T[6] = '{8'ha9, 8'ha8, 8'hac, 8'haa, 8'h98, 8'h88};
	logic [9:0] aT[6] = '{10'h020, 10'h0c8, 10'h020, 10'h100, 10'h020, 10'h020};
	int winT[6] = '{128, 128, 128, 256, 128, 128};
	int hiT[6] = '{32, 128, 96, 128, 128, 0};
	int eaT[6] = '{1, 0, 1, 1, 1, 1};

	always #4 clk = ~clk;

	ctp_timer dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .pinOut(pinOut), .pinOe(pinOe),
		.matchAEvt(matchAEvt), .matchPEvt(matchPEvt));
	ctp_load_model load (.clk(clk), .arst_n(arst_n), .pinOut(pinOut), .pinOe(pinOe),
		.clr(clr), .highCnt(highCnt));

	always @(posedge clk) begin
		if (matchAEvt === 1'b1)
			aCnt++;
		if (matchPEvt === 1'b1)
			pCnt++;
		cyc++;
		if (cyc == 10000) begin
			numErrors++;
			close_out();
		end
	end

	task close_out;
		$display("errors %0d checks %0d", numErrors, samplesChecked);
		if (numErrors == 0 && samplesChecked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	// called just after an edge; the strobe stays up so the next access follows with no gap
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		addr <= a;
		wrData <= v;
		wrStb <= 1'b1;
		rdStb <= 1'b0;
		@(posedge clk);
	endtask : wr

	task idle;
		wrStb <= 1'b0;
		rdStb <= 1'b0;
	endtask : idle

	// data stand only in the cycle after the strobe, taken at the edge that ends it
	task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		addr <= a;
		rdStb <= 1'b1;
		wrStb <= 1'b0;
		@(posedge clk);
		rdStb <= 1'b0;
		@(posedge clk);
		v = rdData;
	endtask : rd

	// load counters and event counts cover exactly win sampled edges
	task window(input int win);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		#1;
		aCnt = 0;
		pCnt = 0;
		repeat (win) @(posedge clk);
		#1;
	endtask : window

	// stop, program, then restart with period value 1 and undivided clock
	task start(input logic [7:0] c1, input logic [9:0] a);
		wr(ADDR_CTRL0, 8'h10);
		wr(ADDR_CTRL1, c1);
		wr(ADDR_CMPA_LO, a[7:0]);
		wr(ADDR_CMPA_HI, {6'h00, a[9:8]});
		wr(ADDR_CTRL0, 8'h19);
		idle();
	endtask : start

	task regs_check;
		rd(ADDR_CMPA_LO, d);
		`CHK(d, 8'h00)
		rd(ADDR_CTRL1, d);
		`CHK(d, 8'h00)
		wr(ADDR_CMPA_HI, 8'hff);
		rd(ADDR_CMPA_HI, d);
		`CHK(d, 8'h03)
		wr(ADDR_CMPA_LO, 8'ha5);
		rd(ADDR_CMPA_LO, d);
		`CHK(d, 8'ha5)
		wr(ADDR_CNT_HI, 8'hff);
		rd(ADDR_CNT_HI, d);
		`CHK(d, 8'h00)
		rd(3'h7, d);
		`CHK(d, 8'h00)
	endtask : regs_check

	task cmp_toggle;
		int i;
		start(8'h31, 10'h0c8);
		repeat (3) @(posedge clk);
		#1;
		`CHK(pinOut, 1'b0)
		i = 0;
		while (matchAEvt !== 1'b1 && i < 300) begin
			@(posedge clk);
			#1;
			i++;
		end
		`CHK(pinOut, 1'b1)
		// period is 200 clocks: the clear lands in the cycle of the next A match
		repeat (199) @(posedge clk);
		wr(ADDR_FLAGS, 8'h01);
		rd(ADDR_FLAGS, d);
		`CHK(d, 8'h01)
		`CHK(pinOut, 1'b0)
		window(300);
		`CHK(aCnt, 1)
		`CHK(pCnt, 0)
		`CHK(pinOut, 1'b1)
		rd(ADDR_FLAGS, d);
		`CHK(d, 8'h01)
		wr(ADDR_CTRL0, 8'h10);
		wr(ADDR_FLAGS, 8'h03);
		rd(ADDR_FLAGS, d);
		`CHK(d, 8'h00)
		wr(ADDR_CTRL1, 8'h39);
		wr(ADDR_CTRL0, 8'h19);
		idle();
		repeat (3) @(posedge clk);
		#1;
		`CHK(pinOut, 1'b1)
	endtask : cmp_toggle

	task cmp_clear_p;
		for (int m = 0; m < 4; m += 3) begin
			start({m[1:0], 6'h18}, 10'h032);
			window(300);
			`CHK(aCnt, 2)
			`CHK(pCnt, 2)
			`CHK(pinOe, (m == 0))
			`CHK(pinOut, 1'b0)
		end
	endtask : cmp_clear_p

	task cmp_zero_a;
		start(8'h31, 10'h000);
		window(1100);
		`CHK(aCnt, 0)
		`CHK(pCnt, 0)
	endtask : cmp_zero_a

	// wave, full duty, inverted, swapped, forced active and inactive
	task pwm_table;
		for (int i = 0; i < 6; i++) begin
			start(c1T[i], aT[i]);
			repeat (4) @(posedge clk);
			window(winT[i]);
			`CHK(highCnt, hiT[i])
			`CHK(aCnt, eaT[i])
			`CHK(pCnt, 1)
		end
	endtask : pwm_table

	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		regs_check();
		cmp_toggle();
		cmp_clear_p();
		cmp_zero_a();
		pwm_table();
		close_out();
	end
endmodule : ctp_timer_tb
`default_nettype wire

// ==== verilog/ctp_pkg.sv ====
// shared constants and state type for the compact ten-bit timer
package ctp_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int CNT_W = 10;
	localparam int PSC_W = 6;

	// byte register map
	localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 3'h6;

	// control byte zero fields
	localparam int C0_ON = 3;
	localparam int C0_RP_LSB = 0;
	localparam int C0_RP_MSB = 2;
	localparam int C0_CKS_LSB = 4;
	localparam int C0_CKS_MSB = 6;
	// control byte one fields
	localparam int C1_MODE_LSB = 6;
	localparam int C1_MODE_MSB = 7;
	localparam int C1_ACT_LSB = 4;
	localparam int C1_ACT_MSB = 5;
	localparam int C1_OC = 3;
	localparam int C1_POL = 2;
	localparam int C1_DPX = 1;
	localparam int C1_CCLR = 0;
	// flag byte fields
	localparam int FLAG_A_BIT = 0;
	localparam int FLAG_P_BIT = 1;

	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_UNDEF = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;

	// pin action codes, compare mode and pwm mode readings
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	localparam logic [1:0] ACT_FORCE_INACT = 2'h0;
	localparam logic [1:0] ACT_FORCE_ACT = 2'h1;
	localparam logic [1:0] ACT_WAVE = 2'h2;

	// counter clock divider masks
	localparam logic [2:0] CKS_DIV4 = 3'h0;
	localparam logic [2:0] CKS_DIV1 = 3'h1;
	localparam logic [2:0] CKS_DIV16 = 3'h2;
	localparam logic [PSC_W-1:0] MASK_DIV1 = 6'h00;
	localparam logic [PSC_W-1:0] MASK_DIV4 = 6'h03;
	localparam logic [PSC_W-1:0] MASK_DIV16 = 6'h0f;
	localparam logic [PSC_W-1:0] MASK_DIV64 = 6'h3f;

	localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
	localparam logic [CNT_W:0] FULL_PERIOD = 11'h400;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

	typedef struct packed {
		logic [PSC_W-1:0] psc;
		logic [CNT_W-1:0] count;
		logic [DATA_W-1:0] ctrl0;
		logic [DATA_W-1:0] ctrl1;
		logic [CNT_W-1:0] cmpA;
		logic flagA;
		logic flagP;
		logic evtA;
		logic evtP;
		logic pinLvl;
		logic pinOut;
		logic pinOe;
		logic onPrev;
		logic [DATA_W-1:0] rdData;
	} ctp_state_s;
endpackage : ctp_pkg

// ==== verilog/ctp_timer.sv ====
// compact ten-bit timer with compare output, timer and edge-aligned pwm modes
// Behaviour
// - compare A split low byte, high bits 1..0
// - count readable as bytes, upper bits zero
// - mode code selects compare, pwm, timer
// - clear low: P match or overflow clears
// - clear high: A match clears, no P flag
// - A value zero: overflow, no A flag
// - compare mode pin moves only on A or counter-on rising edge
// - A match drives high, low, toggles
// - counter-on rising edge restores initial pin level
// - timer mode counts alike, pin unused
// - pwm ignores clear selector, swap bit decides
// - swap zero: period P times 128
// - swap one: period A, duty P
// - duty at least period gives full active
// - pwm raises both flags on matches
// - level bit polarity, action, invert bit
// - pwm counting continues while pin forced
// - compare action codes none, low, high, toggle
// - pwm action codes inactive, active, waveform
// - P is the top three bits of a compare value whose low seven bits are zero
`timescale 1ns/10ps
`default_nettype none
module ctp_timer (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [ctp_pkg::ADDR_W-1:0] addr,
	input wire logic [ctp_pkg::DATA_W-1:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [ctp_pkg::DATA_W-1:0] rdData,
	output logic pinOut,
	output logic pinOe,
	output logic matchAEvt,
	output logic matchPEvt
);
	import ctp_pkg::*;

	ctp_state_s st_reg;
	ctp_state_s st_next;

	logic onBit;
	logic [2:0] rp;
	logic [2:0] cks;
	logic [1:0] mode;
	logic [1:0] pinAct;
	logic oc;
	logic pol;
	logic dpx;
	logic cclr;
	logic pwmMode;
	logic cmpMode;
	logic onRise;
	logic [PSC_W-1:0] divMask;
	logic tick;
	logic [CNT_W:0] cntPlus;
	logic [CNT_W:0] pEdge;
	logic hitA;
	logic hitP;
	logic ovf;
	logic clrByA;
	logic clearNow;
	logic evA;
	logic evP;
	logic [CNT_W-1:0] countNext;
	logic [CNT_W:0] duty;
	logic pwmActive;
	logic pwmLvl;
	logic pwmPin;
	logic cmpPinNext;

	assign onBit = st_reg.ctrl0[C0_ON];
	assign rp = st_reg.ctrl0[C0_RP_MSB:C0_RP_LSB];
	assign cks = st_reg.ctrl0[C0_CKS_MSB:C0_CKS_LSB];
	assign mode = st_reg.ctrl1[C1_MODE_MSB:C1_MODE_LSB];
	assign pinAct = st_reg.ctrl1[C1_ACT_MSB:C1_ACT_LSB];
	assign oc = st_reg.ctrl1[C1_OC];
	assign pol = st_reg.ctrl1[C1_POL];
	assign dpx = st_reg.ctrl1[C1_DPX];
	assign cclr = st_reg.ctrl1[C1_CCLR];
	assign pwmMode = (mode == MODE_PWM);
	assign cmpMode = (mode == MODE_CMP);
	assign onRise = onBit && !st_reg.onPrev;

	// counter clock is a one-cycle enable taken from a free prescaler
	always_comb begin
		unique case (cks)
			CKS_DIV4: divMask = MASK_DIV4;
			CKS_DIV1: divMask = MASK_DIV1;
			CKS_DIV16: divMask = MASK_DIV16;
			default: divMask = MASK_DIV64;
		endcase
	end
	assign tick = onBit && ((st_reg.psc & divMask) == divMask);

	// matches are judged on the value the counter is about to reach
	assign cntPlus = {1'b0, st_reg.count} + 11'h001;
	assign hitA = (cntPlus == {1'b0, st_reg.cmpA});
	assign pEdge = {1'b0, rp, 7'h00};
	assign hitP = (rp != 3'h0) && (cntPlus == pEdge);
	assign ovf = (st_reg.count == CNT_MAX);

	// pwm takes the clearing comparator from the swap bit only
	assign clrByA = pwmMode ? dpx : cclr;
	assign clearNow = clrByA ? (hitA || ((st_reg.cmpA == 10'h000) && ovf))
		: (hitP || ((rp == 3'h0) && ovf));
	// the edge that restarts the counter judges nothing: the old count is stale
	assign evA = tick && hitA && !onRise;
	assign evP = tick && !onRise && (hitP || ((rp == 3'h0) && ovf))
		&& (pwmMode || !cclr);

	always_comb begin
		if (onRise) begin
			countNext = '0;
		end else if (tick) begin
			countNext = clearNow ? '0 : cntPlus[CNT_W-1:0];
		end else begin
			countNext = st_reg.count;
		end
	end

	// duty compare; when duty reaches or passes the period the level never drops
	always_comb begin
		if (dpx) begin
			duty = (rp == 3'h0) ? FULL_PERIOD : pEdge;
		end else begin
			duty = {1'b0, st_reg.cmpA};
		end
	end
	assign pwmActive = ({1'b0, countNext} < duty);
	assign pwmLvl = pwmActive ? oc : !oc;

	always_comb begin
		unique case (pinAct)
			ACT_FORCE_INACT: pwmPin = !oc;
			ACT_FORCE_ACT: pwmPin = oc;
			ACT_WAVE: pwmPin = pwmLvl;
			default: pwmPin = !oc;
		endcase
	end

	always_comb begin
		cmpPinNext = st_reg.pinLvl;
		if (onRise) begin
			cmpPinNext = oc;
		end else if (cmpMode && evA) begin
			unique case (pinAct)
				ACT_NONE: cmpPinNext = st_reg.pinLvl;
				ACT_LOW: cmpPinNext = 1'b0;
				ACT_HIGH: cmpPinNext = 1'b1;
				ACT_TOGGLE: cmpPinNext = !st_reg.pinLvl;
			endcase
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.psc = st_reg.psc + 6'h01;
		st_next.onPrev = onBit;
		st_next.count = countNext;
		st_next.evtA = evA;
		st_next.evtP = evP;
		st_next.pinLvl = cmpPinNext;
		if (pwmMode) begin
			st_next.pinOut = pwmPin ^ pol;
		end else if (cmpMode) begin
			st_next.pinOut = cmpPinNext ^ pol;
		end else begin
			st_next.pinOut = 1'b0;
		end
		st_next.pinOe = pwmMode || cmpMode;
		if (wrStb) begin
			unique case (addr)
				ADDR_CTRL0: st_next.ctrl0 = wrData;
				ADDR_CTRL1: st_next.ctrl1 = wrData;
				ADDR_CMPA_LO: st_next.cmpA[7:0] = wrData;
				ADDR_CMPA_HI: st_next.cmpA[9:8] = wrData[1:0];
				ADDR_FLAGS: begin
					if (wrData[FLAG_A_BIT]) begin
						st_next.flagA = 1'b0;
					end
					if (wrData[FLAG_P_BIT]) begin
						st_next.flagP = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// set after the clear so a same-cycle event survives
		if (evA) begin
			st_next.flagA = 1'b1;
		end
		if (evP) begin
			st_next.flagP = 1'b1;
		end
		st_next.rdData = REG_RESET;
		if (rdStb) begin
			unique case (addr)
				ADDR_CTRL0: st_next.rdData = st_reg.ctrl0;
				ADDR_CTRL1: st_next.rdData = st_reg.ctrl1;
				ADDR_CNT_LO: st_next.rdData = st_reg.count[7:0];
				ADDR_CNT_HI: st_next.rdData = {6'h00, st_reg.count[9:8]};
				ADDR_CMPA_LO: st_next.rdData = st_reg.cmpA[7:0];
				ADDR_CMPA_HI: st_next.rdData = {6'h00, st_reg.cmpA[9:8]};
				ADDR_FLAGS: st_next.rdData = {6'h00, st_reg.flagP, st_reg.flagA};
				default: st_next.rdData = REG_RESET;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdData = st_reg.rdData;
	assign pinOut = st_reg.pinOut;
	assign pinOe = st_reg.pinOe;
	assign matchAEvt = st_reg.evtA;
	assign matchPEvt = st_reg.evtP;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	cnt_hi_read_a: assert property (rdStb && addr == ADDR_CNT_HI |=>
		rdData == {6'h00, $past(st_reg.count[9:8])})
		else $error("counter high byte read wrong");

	cmpa_hi_read_a: assert property (rdStb && addr == ADDR_CMPA_HI |=>
		rdData == {6'h00, $past(st_reg.cmpA[9:8])})
		else $error("compare A high byte read wrong");

	cmpa_write_a: assert property (wrStb && addr == ADDR_CMPA_LO ##1
		rdStb && addr == ADDR_CMPA_LO |=> rdData == $past(wrData, 2))
		else $error("compare A low byte not stored");

	on_rise_restore_a: assert property (onRise && !wrStb |=>
		st_reg.count == 10'h000 && st_reg.pinLvl == $past(oc))
		else $error("counter-on edge did not restore");

	p_clear_a: assert property (tick && cmpMode && !cclr && hitP && !onRise |=>
		st_reg.count == 10'h000 && matchPEvt)
		else $error("P match did not clear counter");

	no_p_flag_a: assert property (!pwmMode && cclr |-> !evP)
		else $error("P flag raised with clear selector high");

	a_zero_ovf_a: assert property (!pwmMode && cclr && st_reg.cmpA == 10'h000
		&& tick && ovf && !onRise |=> st_reg.count == 10'h000 && !matchAEvt)
		else $error("overflow with A zero wrong");

	pin_hold_a: assert property (cmpMode && !evA && !onRise |=>
		st_reg.pinLvl == $past(st_reg.pinLvl))
		else $error("pin moved without A match");

	pin_toggle_a: assert property (cmpMode && evA && pinAct == ACT_TOGGLE && !onRise |=>
		st_reg.pinLvl != $past(st_reg.pinLvl))
		else $error("toggle action failed");

	pin_high_a: assert property (cmpMode && evA && pinAct == ACT_HIGH && !onRise |=>
		st_reg.pinLvl)
		else $error("drive high action failed");

	timer_pin_off_a: assert property (mode == MODE_TMR |=> !pinOe && !pinOut)
		else $error("pin driven in timer mode");

	pwm_oe_a: assert property (pwmMode && !wrStb |=> pinOe)
		else $error("pin not driven in pwm mode");

	pwm_period_p_a: assert property (pwmMode && !dpx && tick && hitP && !onRise |=>
		st_reg.count == 10'h000 && st_reg.flagP)
		else $error("pwm period by P wrong");

	pwm_period_a_a: assert property (pwmMode && dpx && tick && hitA && !onRise |=>
		st_reg.count == 10'h000 && st_reg.flagA)
		else $error("pwm period by A wrong");

	full_duty_a: assert property (pwmMode && !dpx && pinAct == ACT_WAVE && rp != 3'h0
		&& {1'b0, st_reg.cmpA} >= pEdge && !wrStb |=> pinOut == $past(oc ^ pol))
		else $error("full duty not held");

	force_act_a: assert property (pwmMode && pinAct == ACT_FORCE_ACT && !wrStb |=>
		pinOut == $past(oc ^ pol))
		else $error("forced active level wrong");

	force_inact_a: assert property (pwmMode && pinAct == ACT_FORCE_INACT && !wrStb |=>
		pinOut == $past(!oc ^ pol))
		else $error("forced inactive level wrong");

	forced_count_a: assert property (pwmMode && pinAct != ACT_WAVE && tick && !clearNow
		&& !onRise |=> st_reg.count == $past(cntPlus[CNT_W-1:0]))
		else $error("pwm counter stalled while forced");

	flag_set_wins_a: assert property (evA && wrStb && addr == ADDR_FLAGS
		&& wrData[FLAG_A_BIT] |=> st_reg.flagA [*2])
		else $error("flag event lost on clear");

	cnt_lo_read_a: assert property (rdStb && addr == ADDR_CNT_LO |=>
		rdData == $past(st_reg.count[7:0]))
		else $error("counter low byte read wrong");

	cmpa_lo_read_a: assert property (rdStb && addr == ADDR_CMPA_LO |=>
		rdData == $past(st_reg.cmpA[7:0]))
		else $error("compare A low byte read wrong");

	rd_idle_a: assert property (!rdStb |=>
		rdData == REG_RESET)
		else $error("read data not zero when idle");

	cmpa_hi_write_a: assert property (wrStb && addr == ADDR_CMPA_HI |=>
		st_reg.cmpA[9:8] == $past(wrData[1:0]))
		else $error("compare A high bits not stored");

	cnt_read_only_a: assert property (!onBit && wrStb && (addr == ADDR_CNT_LO || addr == ADDR_CNT_HI) |=>
		st_reg.count == $past(st_reg.count))
		else $error("counter bytes took a write");

	a_clear_a: assert property (tick && !pwmMode && cclr && hitA && !onRise |=>
		st_reg.count == 10'h000 && matchAEvt)
		else $error("A match did not clear counter");

	p_no_clear_a: assert property (tick && !pwmMode && cclr && hitP && !hitA && !onRise |=>
		st_reg.count == $past(cntPlus[CNT_W-1:0]))
		else $error("P match cleared with clear selector high");

	pin_low_a: assert property (cmpMode && evA && pinAct == ACT_LOW && !onRise |=>
		!st_reg.pinLvl)
		else $error("drive low action failed");

	cmp_pin_out_a: assert property (cmpMode && !wrStb |=>
		pinOut == (st_reg.pinLvl ^ $past(pol)))
		else $error("compare pin does not follow its level");

	timer_flag_a: assert property (mode == MODE_TMR && tick && hitA && !onRise |=>
		matchAEvt && st_reg.flagA)
		else $error("timer mode lost A match");

	off_hold_a: assert property (!onBit |=>
		st_reg.count == $past(st_reg.count))
		else $error("counter moved while off");

	pwm_p_flag_a: assert property (pwmMode && tick && hitP && !onRise |=>
		matchPEvt && st_reg.flagP)
		else $error("pwm P match not flagged");

	pwm_a_flag_a: assert property (pwmMode && tick && hitA && !onRise |=>
		matchAEvt && st_reg.flagA)
		else $error("pwm A match not flagged");

	flag_hold_a: assert property (st_reg.flagA && !(wrStb && addr == ADDR_FLAGS && wrData[FLAG_A_BIT]) |=>
		st_reg.flagA)
		else $error("flag A dropped without clear");

	flag_clear_a: assert property (!evA && wrStb && addr == ADDR_FLAGS && wrData[FLAG_A_BIT] |=>
		!st_reg.flagA)
		else $error("flag A not cleared");

	p_flag_clear_a: assert property (!evP && wrStb && addr == ADDR_FLAGS && wrData[FLAG_P_BIT] |=>
		!st_reg.flagP)
		else $error("flag P not cleared");

	pwm_no_a_clear_a: assert property (pwmMode && !dpx && cclr && tick && hitA && !hitP && !onRise |=>
		st_reg.count == $past(cntPlus[CNT_W-1:0]))
		else $error("pwm cleared by A with swap low");

	cmp_oe_a: assert property (cmpMode && !wrStb |=>
		pinOe)
		else $error("pin not driven in compare mode");

endmodule : ctp_timer
`default_nettype wire
